//--- core/sliding_average.sv
// Sliding average of one voltage over a window built from sub-interval sums.
`timescale 1ns/100ps
`default_nettype none
module sliding_average #(
    parameter int W     = 16,
    parameter int SLOTS = 10,
    parameter int SUB   = 60
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic         sample_valid,
    input  wire logic [W-1:0] sample,
    output logic      [W-1:0] avg
);
    localparam int SW = W + $clog2(SUB + 1);
    localparam int TW = SW + $clog2(SLOTS + 1);
    localparam int PW = $clog2(SLOTS + 1);
    localparam int CW = $clog2(SUB + 1);

    logic [SW-1:0] ring [SLOTS];
    logic [SW-1:0] sub_sum;
    logic [CW-1:0] sub_count;
    logic [PW-1:0] ptr;
    logic [TW-1:0] total;
    logic [SW-1:0] next_sub;
    logic          sub_done;

    assign next_sub = sub_sum + SW'(sample);
    assign sub_done = sample_valid && (sub_count == CW'(SUB - 1));

    // Sub-interval accumulation of incoming samples.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sub_sum   <= '0;
            sub_count <= '0;
        end else if (ce && sample_valid) begin
            sub_sum   <= sub_done ? '0 : next_sub;
            sub_count <= sub_done ? '0 : sub_count + CW'(1);
        end
    end

    // Ring of sub-interval sums; the oldest leaves the running total.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < SLOTS; i++) begin
                ring[i] <= '0;
            end
            ptr   <= '0;
            total <= '0;
            avg   <= '0;
        end else if (ce && sub_done) begin
            ring[ptr] <= next_sub;
            total     <= total + TW'(next_sub) - TW'(ring[ptr]);
            ptr       <= (ptr == PW'(SLOTS - 1)) ? '0 : ptr + PW'(1);
            avg       <= W'((total + TW'(next_sub) - TW'(ring[ptr])) / TW'(SLOTS * SUB));
        end
    end
endmodule // sliding_average
`default_nettype wire

//--- core/voltage_protection_stage.sv
// One voltage protection stage: thresholds, voting, hysteresis, blocking and delays.
//
// What this block does
// RULE1: Phase-to-neutral connection: flags follow phases one-three, or V12, V23, V31 when measuring phase-to-phase.
// RULE2: Phase-to-phase connection: flags follow V12, V23, V31.
// RULE3: Modes unused/over/under/timed-under; defaults per stage index.
// RULE4: Evaluate fundamental, true RMS or sliding average.
// RULE5: Sliding average never chosen with timed under-voltage.
// RULE6: Under and over stages supervise ten-minute sliding average.
// RULE7: Phase-ground nominal is rating/root3, phase-phase is rating.
// RULE8: Phase-to-phase connection forces phase-to-phase measuring mode.
// RULE9: Pick up on any one, any two or all phases.
// RULE10: Dropout ratio sets release level hysteresis.
// RULE11: Either enabled external block input blocks whole stage.
// RULE12: Enabled external trip-block input suppresses trip only.
// RULE13: Block enables act only when input is assigned.
// RULE14: Permanent trip block suppresses trip unconditionally.
// RULE15: Alarm on pickup, trip after stage delay persists.
`timescale 1ns/100ps
`include "vps_consts.svh"
`default_nettype none
module voltage_protection_stage
    import vps_pkg::*;
#(
    parameter int W           = 16,
    parameter int STAGE_INDEX = 1,
    parameter int MS_CYCLES   = `CLK_HZ / `MS_PER_S,
    parameter int AVG_SUB     = `AVG_WINDOW_S * `AVG_SAMPLE_HZ / `AVG_SLOTS
) (
    input  wire logic                     ref_clk,
    input  wire logic                     rst_n,
    input  wire logic                     ce,
    input  wire logic                     transformer_connection,
    input  wire logic [W-1:0]             transformer_secondary_rating,
    input  wire logic                     mode_override,
    input  wire stage_mode_type           mode_select,
    input  wire method_type               method_select,
    input  wire logic                     measure_phase_phase,
    input  wire vote_type                 vote_select,
    input  wire logic [15:0]              pickup_pu,
    input  wire logic [9:0]               dropout_ratio,
    input  wire logic [15:0]              delay_ms,
    input  wire logic [`PHASES-1:0][W-1:0] chan_fund,
    input  wire logic [`PHASES-1:0][W-1:0] chan_rms,
    input  wire logic [`PHASES-1:0][W-1:0] line_fund,
    input  wire logic [`PHASES-1:0][W-1:0] line_rms,
    input  wire logic                     avg_sample_valid,
    input  wire logic                     ext_block_input_a,
    input  wire logic                     ext_block_input_b,
    input  wire logic                     ext_block_a_assigned,
    input  wire logic                     ext_block_b_assigned,
    input  wire logic                     ext_block_enable,
    input  wire logic                     ext_trip_block_input,
    input  wire logic                     ext_trip_block_assigned,
    input  wire logic                     ext_trip_block_enable,
    input  wire logic                     permanent_trip_block,
    output logic      [`PHASES-1:0]       alarm_flags,
    output logic      [`PHASES-1:0]       trip_flags,
    output logic                          alarm,
    output logic                          trip,
    output logic                          blocked
);
    localparam int TW = 32;
    localparam int LW = 48;
    localparam int MW = $clog2(MS_CYCLES + 1);

    function automatic stage_mode_type default_mode(input int idx);
        case (idx)
            1:       default_mode = mode_over;
            2:       default_mode = mode_under;
            default: default_mode = mode_unused;
        endcase
    endfunction

    function automatic logic [1:0] vote_need(input vote_type v);
        case (v)
            vote_any_two: vote_need = 2'h2;
            vote_all:     vote_need = 2'h3;
            default:      vote_need = 2'h1;
        endcase
    endfunction

    stage_mode_type              mode;
    method_type                  method;
    logic                        pp_mode;
    logic                        use_line;
    logic [`PHASES-1:0][W-1:0]   volt;
    logic [`PHASES-1:0][W-1:0]   rms_sel;
    logic [`PHASES-1:0][W-1:0]   avg_volt;
    logic [W-1:0]                vn;
    logic [TW-1:0]               thr;
    logic [TW-1:0]               rel;
    logic [`PHASES-1:0]          pick;
    logic [1:0]                  pick_count;
    logic                        over;
    logic                        active;
    logic                        stage_block;
    logic                        trip_block;
    logic                        stage_pick;
    logic [TW-1:0]               deficit;
    logic [MW-1:0]               ms_count;
    logic                        ms_tick;
    logic [LW-1:0]               elapsed;
    logic                        expired;
    stage_state_type             state;
    stage_state_type             next_state;

    assign mode     = mode_override ? mode_select : default_mode(STAGE_INDEX); // RULE3
    assign method   = (mode == mode_tdep && method_select == method_avg)
                      ? method_fund : method_select; // RULE5
    assign pp_mode  = transformer_connection || measure_phase_phase; // RULE8
    assign use_line = !transformer_connection && measure_phase_phase;
    assign over     = (mode == mode_over);
    assign active   = (mode != mode_unused);

    // Channel n feeds flag n; channels carry phases or line pairs per connection.
    always_comb begin
        for (int i = 0; i < `PHASES; i++) begin
            rms_sel[i] = use_line ? line_rms[i] : chan_rms[i]; // RULE1 RULE2
            case (method) // RULE4
                method_rms: volt[i] = rms_sel[i];
                method_avg: volt[i] = avg_volt[i]; // RULE6
                default:    volt[i] = use_line ? line_fund[i] : chan_fund[i];
            endcase
        end
    end

    for (genvar g = 0; g < `PHASES; g++) begin : g_avg
        sliding_average #(
            .W     (W),
            .SLOTS (`AVG_SLOTS),
            .SUB   (AVG_SUB)
        ) u_avg (
            .ref_clk      (ref_clk),
            .rst_n        (rst_n),
            .ce           (ce),
            .sample_valid (avg_sample_valid),
            .sample       (rms_sel[g]),
            .avg          (avg_volt[g])
        ); // RULE6
    end

    assign vn  = pp_mode ? transformer_secondary_rating
               : W'((TW'(transformer_secondary_rating) * TW'(`INV_SQRT3_Q16))
                    >> `Q16_SHIFT); // RULE7
    assign thr = TW'((LW'(vn) * LW'(pickup_pu)) >> `Q8_SHIFT);
    assign rel = TW'((LW'(thr) * LW'(dropout_ratio)) >> `Q8_SHIFT); // RULE10

    assign stage_block = ext_block_enable &&
                         ((ext_block_a_assigned && ext_block_input_a) ||
                          (ext_block_b_assigned && ext_block_input_b)); // RULE11 RULE13
    assign trip_block  = permanent_trip_block ||
                         (ext_trip_block_enable && ext_trip_block_assigned &&
                          ext_trip_block_input); // RULE12 RULE13 RULE14

    // Per-phase pickup with release at the dropout level.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pick <= '0;
        end else if (ce) begin
            for (int i = 0; i < `PHASES; i++) begin
                if (!active || stage_block) begin
                    pick[i] <= 1'b0;
                end else if (!pick[i]) begin
                    pick[i] <= over ? (TW'(volt[i]) > thr) : (TW'(volt[i]) < thr);
                end else begin
                    pick[i] <= over ? (TW'(volt[i]) >= rel) : (TW'(volt[i]) <= rel); // RULE10
                end
            end
        end
    end

    assign pick_count = 2'(pick[0]) + 2'(pick[1]) + 2'(pick[2]);
    assign stage_pick = active && !stage_block && (pick_count >= vote_need(vote_select)); // RULE9

    // Largest shortfall below threshold drives the timed under-voltage integrator.
    always_comb begin
        deficit = '0;
        for (int i = 0; i < `PHASES; i++) begin
            if (pick[i] && thr > TW'(volt[i]) && (thr - TW'(volt[i])) > deficit) begin
                deficit = thr - TW'(volt[i]);
            end
        end
    end

    // Millisecond time base.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ms_count <= '0;
            ms_tick  <= 1'b0;
        end else if (ce) begin
            ms_tick  <= (ms_count == MW'(MS_CYCLES - 1));
            ms_count <= (ms_count == MW'(MS_CYCLES - 1)) ? '0 : ms_count + MW'(1);
        end
    end

    assign expired = (mode == mode_tdep)
                     ? (elapsed >= LW'(delay_ms) * LW'(thr))
                     : (elapsed >= LW'(delay_ms));

    always_comb begin
        case (state)
            st_idle:  next_state = stage_pick ? st_alarm : st_idle;
            st_alarm: next_state = !stage_pick ? st_idle : (expired ? st_trip : st_alarm);
            st_trip:  next_state = stage_pick ? st_trip : st_idle;
            default:  next_state = st_idle;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= st_idle;
        end else if (ce) begin
            state <= next_state; // RULE15
        end
    end

    // Delay timer in milliseconds, or integrated shortfall for the timed mode.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            elapsed <= '0;
        end else if (ce) begin
            if (state != st_alarm || !stage_pick) begin
                elapsed <= '0;
            end else if (ms_tick) begin
                elapsed <= elapsed + ((mode == mode_tdep) ? LW'(deficit) : LW'(1)); // RULE15
            end
        end
    end

    // Registered flags.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            alarm_flags <= '0;
            trip_flags  <= '0;
            alarm       <= 1'b0;
            trip        <= 1'b0;
            blocked     <= 1'b0;
        end else if (ce) begin
            alarm_flags <= (next_state != st_idle) ? pick : '0; // RULE15 RULE1 RULE2
            trip_flags  <= (next_state == st_trip && !trip_block) ? pick : '0; // RULE12 RULE14
            alarm       <= (next_state != st_idle);
            trip        <= (next_state == st_trip) && !trip_block; // RULE12 RULE14
            blocked     <= stage_block; // RULE11
        end
    end
endmodule // voltage_protection_stage
`default_nettype wire

//--- core/vps_consts.svh
// Timing, scaling and encoding constants of the voltage protection stage.
`ifndef VPS_CONSTS_SVH
`define VPS_CONSTS_SVH
`define CLK_HZ          50000000
`define MS_PER_S        1000
`define AVG_WINDOW_S    600
`define AVG_SLOTS       10
`define AVG_SAMPLE_HZ   1
`define INV_SQRT3_Q16   16'h93cd
`define Q16_SHIFT       16
`define Q8_SHIFT        8
`define PU_ONE_Q8       16'h0100
`define DROPOUT_DEF_Q8  10'h0f3
`define PHASES          3
`endif

//--- core/vps_pkg.sv
// Types shared by the voltage protection stage files.
package vps_pkg;
    typedef enum logic [1:0] {
        mode_unused  = 2'h0,
        mode_over    = 2'h1,
        mode_under   = 2'h2,
        mode_tdep    = 2'h3
    } stage_mode_type;
    typedef enum logic [1:0] {
        method_fund  = 2'h0,
        method_rms   = 2'h1,
        method_avg   = 2'h2
    } method_type;
    typedef enum logic [1:0] {
        vote_any_one = 2'h0,
        vote_any_two = 2'h1,
        vote_all     = 2'h2
    } vote_type;
    typedef enum logic [2:0] {
        st_idle      = 3'h1,
        st_alarm     = 3'h2,
        st_trip      = 3'h4
    } stage_state_type;
endpackage

//--- tb/tb_top.sv
// Self-checking bench for the voltage protection stage.
`timescale 1ns/100ps
`include "vps_consts.svh"
`default_nettype none
module tb_top import vps_pkg::*; ();
    localparam logic [15:0] HI = 16'h3000;
    localparam logic [15:0] LO = 16'h1000;
    logic             ref_clk = 1'b0;
    logic             rst_n = 1'b0;
    logic             conn, ovr, mpp, perm, blk_a, blk_b, asg_a, asg_b;
    logic             avs = 1'b0;
    logic             ce_in = 1'b1;
    logic             blk_en, tb_in, tb_asg, tb_en, al, tr, bl;
    stage_mode_type   mode;
    method_type       meth;
    vote_type         vote;
    logic [9:0]       ratio;
    logic [15:0]      rating, pickup, dly;
    logic [2:0][15:0] volts, cf, cr, lf, lr;
    logic [2:0]       af, tf;
    logic [31:0]      seed = 32'h1a3d;
    int               miscompares = 0;
    int               total_checks = 0;
    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) avs <= ~avs;
    vt_source vt (.volts(volts), .chan_fund(cf), .chan_rms(cr), .line_fund(lf), .line_rms(lr));
    voltage_protection_stage #(.STAGE_INDEX(1), .MS_CYCLES(4), .AVG_SUB(2)) uut (
        .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce_in), .transformer_connection(conn),
        .transformer_secondary_rating(rating), .mode_override(ovr), .mode_select(mode),
        .method_select(meth), .measure_phase_phase(mpp), .vote_select(vote),
        .pickup_pu(pickup), .dropout_ratio(ratio), .delay_ms(dly), .chan_fund(cf),
        .chan_rms(cr), .line_fund(lf), .line_rms(lr), .avg_sample_valid(avs),
        .ext_block_input_a(blk_a), .ext_block_input_b(blk_b), .ext_block_a_assigned(asg_a),
        .ext_block_b_assigned(asg_b), .ext_block_enable(blk_en), .ext_trip_block_input(tb_in),
        .ext_trip_block_assigned(tb_asg), .ext_trip_block_enable(tb_en),
        .permanent_trip_block(perm), .alarm_flags(af), .trip_flags(tf), .alarm(al),
        .trip(tr), .blocked(bl));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [15:0] eff(input int i);
        if (!conn && mpp) return (meth == method_rms) ? lr[i] : lf[i];
        return (meth == method_rms) ? cr[i] : cf[i];
    endfunction
    function automatic logic [2:0] exp_flags();
        logic [2:0]  p;
        logic [31:0] t;
        t = (conn | mpp) ? 32'(rating) : (32'(rating) * 32'(`INV_SQRT3_Q16)) >> `Q16_SHIFT;
        t = (t * 32'(pickup)) >> `Q8_SHIFT;
        for (int i = 0; i < 3; i++) p[i] = (mode == mode_over) ? eff(i) > t : eff(i) < t;
        if (vote == vote_all) return (p == 3'h7) ? p : 3'h0;
        if (vote == vote_any_two) return ($countones(p) > 1) ? p : 3'h0;
        return p;
    endfunction
    task automatic check(input logic [4:0] seen, input logic [4:0] want);
        total_checks++;
        if (seen !== want) begin
            miscompares++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task automatic put(input logic [2:0][15:0] v, input int n);
        @(posedge ref_clk);
        volts <= v;
        step(n);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        {mpp, perm, blk_a, blk_b, asg_a, asg_b, blk_en, tb_in, tb_asg, tb_en, ovr} = '0;
        conn = 1'b1;
        mode = mode_unused;
        meth = method_fund;
        vote = vote_any_one;
        ratio = 10'h100;
        dly = 16'h0;
        {rating, pickup, volts} = {16'h2000, 16'h0100, LO, LO, LO};
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        put({LO, LO, HI}, 3);
        check(5'({af, tf}), 5'h09);
        @(posedge ref_clk);
        ovr <= 1'b1;
        step(3);
        check(5'(al), 5'h0);
        @(posedge ref_clk);
        mode <= mode_over;
        {blk_en, blk_a} <= 2'h3;
        step(3);
        check(5'(bl), 5'h0);
        @(posedge ref_clk);
        asg_a <= 1'b1;
        step(3);
        check(5'({bl, af}), 5'h08);
        @(posedge ref_clk);
        {blk_a, asg_a, blk_b, asg_b} <= 4'h3;
        step(3);
        check(5'({bl, af}), 5'h08);
        @(posedge ref_clk);
        {blk_en, tb_in, tb_en} <= 3'h3;
        step(3);
        check(5'({al, tr}), 5'h3);
        @(posedge ref_clk);
        tb_asg <= 1'b1;
        step(2);
        check(5'({al, tr, tf}), 5'h10);
        @(posedge ref_clk);
        {tb_in, perm} <= 2'h1;
        step(2);
        check(5'({al, tr}), 5'h2);
        @(posedge ref_clk);
        {perm, dly} <= {1'b0, 16'h2};
        put({LO, LO, LO}, 3);
        put({LO, LO, HI}, 3);
        check(5'({al, tr}), 5'h2);
        step(16);
        check(5'(tr), 5'h1);
        @(posedge ref_clk);
        {dly, ratio} <= {16'h0, 10'h0c0};
        put({LO, LO, 16'h1c00}, 3);
        check(5'(al), 5'h1);
        put({LO, LO, 16'h1400}, 3);
        check(5'(al), 5'h0);
        @(posedge ref_clk);
        ratio <= 10'h100;
        meth <= method_avg;
        step(50);
        put({LO, LO, HI}, 3);
        check(5'(al), 5'h0);
        step(60);
        check(5'(al), 5'h1);
        repeat (200) begin
            seed = xs(seed);
            @(posedge ref_clk);
            {conn, mpp} <= seed[1:0];
            meth <= method_type'({1'b0, seed[2]});
            vote <= vote_type'(seed[4:3] % 2'h3);
            mode <= stage_mode_type'(seed[6:5] % 2'h3 + 2'h1);
            volts <= {1'b0, seed[31:21], 4'h5, 1'b0, seed[20:10], 4'h5, 1'b0, seed[10:0], 4'h5};
            step(4);
            check(5'(af), 5'(exp_flags()));
            if (mode != mode_tdep) check(5'(tf), 5'(exp_flags()));
        end
        @(posedge ref_clk);
        conn <= 1'b1;
        meth <= method_fund;
        vote <= vote_any_one;
        mode <= mode_tdep;
        dly <= 16'h2;
        put({HI, HI, HI}, 4);
        check(5'({al, tr}), 5'h0);
        put({HI, HI, LO}, 12);
        check(5'({al, tr}), 5'h2);
        step(11);
        check(5'({al, tr}), 5'h3);
        @(posedge ref_clk);
        ce_in <= 1'b0;
        put({HI, HI, HI}, 4);
        check(5'({al, tr}), 5'h3);
        @(posedge ref_clk);
        ce_in <= 1'b1;
        step(3);
        check(5'({al, tr}), 5'h0);
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        wrap_up();
    end
endmodule // tb_top
`default_nettype wire

//--- tb/vps_sva.sv
// Checker bound to the voltage protection stage ports.
`timescale 1ns/100ps
`default_nettype none
module vps_sva
    import vps_pkg::*;
(
    input wire logic           ref_clk,
    input wire logic           rst_n,
    input wire logic           mode_override,
    input wire stage_mode_type mode_select,
    input wire vote_type       vote_select,
    input wire logic           ext_block_input_a,
    input wire logic           ext_block_input_b,
    input wire logic           ext_block_a_assigned,
    input wire logic           ext_block_b_assigned,
    input wire logic           ext_block_enable,
    input wire logic           ext_trip_block_input,
    input wire logic           ext_trip_block_assigned,
    input wire logic           ext_trip_block_enable,
    input wire logic           permanent_trip_block,
    input wire logic [2:0]     alarm_flags,
    input wire logic [2:0]     trip_flags,
    input wire logic           alarm,
    input wire logic           trip,
    input wire logic           blocked
);
    logic sblk;
    logic tblk;
    assign sblk = ext_block_enable && ((ext_block_a_assigned && ext_block_input_a)
                  || (ext_block_b_assigned && ext_block_input_b));
    assign tblk = ext_trip_block_enable && ext_trip_block_assigned && ext_trip_block_input;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    chk_block_clears: assert property (sblk [*3] |-> blocked && !alarm && !trip)
        else $error("stage not blocked");
    chk_block_cause: assert property (blocked |-> $past(sblk))
        else $error("blocked without cause");
    chk_trip_ext: assert property (tblk [*2] |-> !trip && trip_flags == 3'h0)
        else $error("trip passed trip block");
    chk_trip_perm: assert property (permanent_trip_block [*2] |-> !trip)
        else $error("trip passed permanent block");
    chk_trip_alarm: assert property (
        trip |-> alarm && (trip_flags & ~alarm_flags) == 3'h0)
        else $error("trip without alarm");
    chk_trip_late: assert property ($rose(trip) |-> $past(alarm))
        else $error("trip before alarm");
    chk_unused_quiet: assert property (
        (mode_override && mode_select == mode_unused) [*3] |-> !alarm && !trip)
        else $error("unused stage flags");
    chk_vote_all: assert property (
        (vote_select == vote_all) [*3] ##0 alarm |-> alarm_flags == 3'h7)
        else $error("all vote on fewer phases");
    chk_alarm_sum: assert property (alarm == (alarm_flags != 3'h0))
        else $error("alarm and flags disagree");
    cover property (sblk ##1 blocked);
    cover property ($rose(trip));
    cover property (alarm && vote_select == vote_any_two);
    cover property (mode_override && mode_select == mode_tdep && $rose(trip));
endmodule // vps_sva
bind voltage_protection_stage vps_sva chk (
    .ref_clk, .rst_n, .mode_override, .mode_select, .vote_select, .ext_block_input_a,
    .ext_block_input_b, .ext_block_a_assigned, .ext_block_b_assigned, .ext_block_enable,
    .ext_trip_block_input, .ext_trip_block_assigned, .ext_trip_block_enable,
    .permanent_trip_block, .alarm_flags, .trip_flags, .alarm, .trip, .blocked
);
`default_nettype wire

//--- tb/vt_source.sv
// Transformer model producing channel and line magnitudes.
`timescale 1ns/100ps
`default_nettype none
module vt_source (
    input  wire logic [2:0][15:0] volts,
    output logic      [2:0][15:0] chan_fund,
    output logic      [2:0][15:0] chan_rms,
    output logic      [2:0][15:0] line_fund,
    output logic      [2:0][15:0] line_rms
);
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            chan_fund[i] = volts[i];
            chan_rms[i] = volts[i] + 16'h0040;
            line_fund[i] = 16'((32'(volts[i]) * 32'h1bb) >> 8);
            line_rms[i] = line_fund[i] + 16'h0040;
        end
    end
endmodule // vt_source
`default_nettype wire
